// file: rtl/lk_pkg.sv
package lk_pkg;
  // task-file contents: _cur is the latest write, _prev the one before
  typedef struct packed {
    logic [7:0] devctl;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sn_cur;
    logic [7:0] sn_prev;
    logic [7:0] cl_cur;
    logic [7:0] cl_prev;
    logic [7:0] ch_cur;
    logic [7:0] ch_prev;
    logic [7:0] devhead;
    logic [7:0] command;
  } task_file_t;
  // values read back with the high-order selector clear (_lo) and set (_hi)
  typedef struct packed {
    logic [7:0] error;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] sn_lo;
    logic [7:0] sn_hi;
    logic [7:0] cl_lo;
    logic [7:0] cl_hi;
    logic [7:0] ch_lo;
    logic [7:0] ch_hi;
    logic [7:0] devhead;
    logic [7:0] status;
    logic [3:0] state;
    logic host_fault;
  } err_event_t;
  typedef struct packed {
    logic [7:0] number;
    logic [7:0] exec_status;
    logic [7:0] checkpoint;
    logic [47:0] lba;
    logic legacy28;
  } selftest_t;
endpackage : lk_pkg

// file: rtl/log_keeper.sv
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "log_keeper_params.svh"
module log_keeper #(
  parameter int unsigned CYC_PER_MS = `LK_MS_NS / `LK_CLK_NS
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic cmd_valid, // pulse: a command was issued
  input wire lk_pkg::task_file_t cmd_tf, // task file of that command
  input wire logic err_valid, // pulse: an error was reported
  input wire lk_pkg::err_event_t err_ev, // error details
  input wire logic st_valid, // pulse: a self-test finished
  input wire lk_pkg::selftest_t st_res, // self-test result
  input wire logic [15:0] life_hours, // power-on lifetime hours
  output logic log_abort // selected log is refused
);
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic abort_q;
  logic dir_en_q;
  logic [7:0] sel_log_q;
  logic [7:0] sel_sec_q;
  logic [8:0] ofs_q;
  logic [2:0] err_idx_q;
  logic [4:0] st_idx_q;
  logic [15:0] err_cnt_q;
  logic [31:0] ms_q;
  logic [31:0] div_q;
  logic [7:0] err_mem [0:`LK_ERR_MEM-1];
  logic [7:0] st_mem [0:`LK_ST_MEM-1];
  lk_pkg::task_file_t hist_q [0:`LK_CMD_HIST-1];
  logic [31:0] hist_ts_q [0:`LK_CMD_HIST-1];
  logic [7:0] err_entry [0:`LK_ERR_ENTRY-1];
  logic [7:0] st_entry [0:`LK_ST_ENTRY-1];
  logic [2:0] err_next;
  logic [4:0] st_next;
  logic err_take;
  logic done;
  logic [47:0] st_lba;
  logic [7:0] rd_byte;
  logic [31:0] rd_word;
  logic rd_err;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign log_abort = abort_q;
  assign done = psel && penable && pready_q;
  // host faults neither logged nor counted
  assign err_take = err_valid && !err_ev.host_fault;

  // advance one slot, wrapping last back to first
  assign err_next = (err_idx_q == `LK_ERR_MAX_IDX) ? 3'h1 : err_idx_q + 3'h1;
  assign st_next = (st_idx_q == `LK_ST_MAX_IDX) ? 5'h01 : st_idx_q + 5'h01;
  assign st_lba = st_res.legacy28 ? {20'h0, st_res.lba[27:0]} : st_res.lba;

  // power-on millisecond clock for command timestamps
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_q <= 32'h0;
      ms_q <= 32'h0;
    end
    else if (div_q == CYC_PER_MS - 1)
    begin
      div_q <= 32'h0;
      ms_q <= ms_q + 32'h1;
    end
    else
      div_q <= div_q + 32'h1;
  end

  // last five commands, oldest in entry 0
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `LK_CMD_HIST; k++)
      begin
        hist_q[k] <= '0;
        hist_ts_q[k] <= 32'h0;
      end
    end
    else if (cmd_valid)
    begin
      for (int k = 0; k < `LK_CMD_HIST - 1; k++)
      begin
        hist_q[k] <= hist_q[k+1];
        hist_ts_q[k] <= hist_ts_q[k+1];
      end
      hist_q[`LK_CMD_HIST-1] <= cmd_tf;
      hist_ts_q[`LK_CMD_HIST-1] <= ms_q;
    end
  end

  // assemble one 124-byte error entry
  always_comb
  begin
    for (int j = 0; j < `LK_ERR_ENTRY; j++)
      err_entry[j] = 8'h00;
    // five command records ahead of the error record
    for (int k = 0; k < `LK_CMD_HIST; k++)
    begin
      // current and previous task file plus timestamp
      for (int j = 0; j < $bits(lk_pkg::task_file_t) / 8; j++)
        err_entry[k*`LK_CMD_REC+j] = hist_q[k][$bits(lk_pkg::task_file_t) - 1 - 8*j -: 8];
      for (int b = 0; b < 4; b++)
        err_entry[k*`LK_CMD_REC+`LK_TS_OFS+b] = hist_ts_q[k][8*b +: 8];
    end
    // error, status and both task-file views, hours
    for (int j = 0; j < `LK_REC_STATUS; j++)
      err_entry[`LK_ERR_REC_OFS+1+j] = err_ev[$bits(lk_pkg::err_event_t) - 1 - 8*j -: 8];
    // device state in the low nibble
    err_entry[`LK_ERR_REC_OFS+`LK_REC_STATE] = {4'h0, err_ev.state};
    err_entry[`LK_ERR_REC_OFS+`LK_REC_LIFE] = life_hours[7:0];
    err_entry[`LK_ERR_REC_OFS+`LK_REC_LIFE+1] = life_hours[15:8];
  end

  // assemble one 26-byte self-test descriptor
  always_comb
  begin
    for (int j = 0; j < `LK_ST_ENTRY; j++)
      st_entry[j] = 8'h00;
    st_entry[0] = st_res.number;
    st_entry[1] = st_res.exec_status;
    st_entry[2] = life_hours[7:0];
    st_entry[3] = life_hours[15:8];
    st_entry[4] = st_res.checkpoint;
    // 48-bit lba; a 28-bit result keeps only its low bits
    for (int b = 0; b < 6; b++)
      st_entry[`LK_ST_LBA_OFS+b] = st_lba[8*b +: 8];
  end

  // error log slots, index and lifetime count
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `LK_ERR_MEM; i++)
        err_mem[i] <= 8'h00;
      err_idx_q <= 3'h0;
      err_cnt_q <= 16'h0;
    end
    else if (err_take)
    begin
      // newest error overwrites the oldest slot
      for (int i = 0; i < `LK_ERR_MEM; i++)
        if (i / `LK_ERR_ENTRY == int'(err_next) - 1)
          err_mem[i] <= err_entry[i % `LK_ERR_ENTRY];
      // index points to the newest entry
      err_idx_q <= err_next;
      // count device errors; hold at the top
      if (err_cnt_q != `LK_CNT_MAX)
        err_cnt_q <= err_cnt_q + 16'h1;
    end
  end

  // self-test descriptors and index
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `LK_ST_MEM; i++)
        st_mem[i] <= 8'h00;
      st_idx_q <= 5'h0;
    end
    else if (st_valid)
    begin
      // legacy results are kept here with 48-bit ones
      // nineteenth self-test lands in descriptor 1 again
      for (int i = 0; i < `LK_ST_MEM; i++)
        if (i / `LK_ST_ENTRY == int'(st_next) - 1)
          st_mem[i] <= st_entry[i % `LK_ST_ENTRY];
      st_idx_q <= st_next;
    end
  end

  // one byte of the selected sector, checksum byte excluded
  function automatic logic [7:0] sector_byte(input logic [7:0] log, input logic [8:0] ofs);
    logic [7:0] addr;
    logic [15:0] len;
    logic [7:0] b;
    addr = ofs[8:1];
    len = 16'h0;
    b = 8'h00;
    case (log)
      `LK_LOG_DIR:
      begin
        // length word per log at twice its address, low byte first
        if (addr == `LK_LOG_ERR || addr == `LK_LOG_ST)
          len = `LK_ONE_SECTOR;
        // host logs are sixteen sectors each
        else if (addr >= `LK_HOST_LO && addr <= `LK_HOST_HI)
          len = `LK_HOST_SECTORS;
        if (addr == 8'h00)
          len = `LK_GPL_VERSION;
        // a disabled directory reads all zero, version 0000h
        if (!dir_en_q)
          len = 16'h0;
        b = ofs[0] ? len[15:8] : len[7:0];
      end
      `LK_LOG_ERR:
      begin
        // version byte, then index and slots
        if (ofs == 9'h000)
          b = `LK_LOG_VERSION;
        else if (ofs == `LK_OFS_IDX_LO)
          b = {5'h0, err_idx_q};
        else if (ofs >= `LK_OFS_ENTRIES && ofs <= `LK_OFS_ERR_END)
          b = err_mem[ofs - `LK_OFS_ENTRIES];
        else if (ofs == `LK_OFS_CNT_LO)
          b = err_cnt_q[7:0];
        else if (ofs == `LK_OFS_CNT_HI)
          b = err_cnt_q[15:8];
      end
      `LK_LOG_ST:
      begin
        // revision, two-byte index, descriptors from 04h
        if (ofs == 9'h000)
          b = `LK_LOG_VERSION;
        else if (ofs == `LK_OFS_IDX_LO)
          b = {3'h0, st_idx_q};
        else if (ofs >= `LK_OFS_ENTRIES && ofs <= `LK_OFS_ST_END)
          b = st_mem[ofs - `LK_OFS_ENTRIES];
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction : sector_byte

  // a log the device does not hold, or a sector past its end
  function automatic logic sel_bad_w(input logic [7:0] log, input logic [7:0] sec);
    logic bad;
    bad = 1'b1;
    if (log == `LK_LOG_DIR || log == `LK_LOG_ERR || log == `LK_LOG_ST)
      bad = (sec != 8'h00);
    else if (log >= `LK_HOST_LO && log <= `LK_HOST_HI)
      bad = (sec >= `LK_HOST_SECTORS);
    return bad;
  endfunction : sel_bad_w

  // byte under the read pointer; the checksum is summed on demand
  // to save an adder on every log update, at the cost of a wide tree
  always_comb
  begin
    logic [7:0] sum;
    sum = 8'h00;
    rd_byte = 8'h00;
    if (!sel_bad_w(sel_log_q, sel_sec_q))
    begin
      if (ofs_q == `LK_OFS_CKSUM)
      begin
        for (int i = 0; i < `LK_SUM_LAST; i++)
          sum = sum + sector_byte(sel_log_q, i[8:0]);
        // two's complement makes the sector sum zero
        rd_byte = 8'h00 - sum;
      end
      else
        rd_byte = sector_byte(sel_log_q, ofs_q);
    end
  end

  // apb read mux and error decode
  always_comb
  begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      `LK_REG_CTRL: rd_word = {31'h0, dir_en_q};
      `LK_REG_LOG_SEL: rd_word = {16'h0, sel_sec_q, sel_log_q};
      `LK_REG_BYTE_OFS: rd_word = {23'h0, ofs_q};
      `LK_REG_DATA:
      begin
        rd_word = {24'h0, rd_byte};
        rd_err = pwrite || abort_q;
      end
      `LK_REG_STATUS: rd_word = {err_cnt_q, 3'h0, st_idx_q, 4'h0, err_idx_q, abort_q};
      default: rd_err = 1'b1;
    endcase
  end

  // one wait state: ready rises on the second access cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_word : 32'h0;
      pslverr_q <= psel && penable && !pready_q && rd_err;
    end
  end

  // software-written selection and control
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dir_en_q <= `LK_CTRL_RESET;
      sel_log_q <= `LK_LOG_DIR;
      sel_sec_q <= 8'h00;
      ofs_q <= 9'h000;
    end
    else if (done && pwrite && paddr == `LK_REG_CTRL)
      dir_en_q <= pwdata[0];
    else if (done && pwrite && paddr == `LK_REG_LOG_SEL)
    begin
      sel_log_q <= pwdata[7:0];
      sel_sec_q <= pwdata[15:8];
      ofs_q <= 9'h000;
    end
    else if (done && pwrite && paddr == `LK_REG_BYTE_OFS)
      ofs_q <= pwdata[8:0];
    else if (done && !pwrite && paddr == `LK_REG_DATA)
      ofs_q <= ofs_q + 9'h001;
  end

  // abort flag: a refused selection sets it, a valid selection or status write-one clears it
  always_ff @(posedge clk)
  begin
    if (rst)
      abort_q <= 1'b0;
    // legacy self-test address or bad selection is refused
    else if (done && pwrite && paddr == `LK_REG_LOG_SEL)
      abort_q <= pwdata[7:0] == `LK_LOG_ST_OLD || sel_bad_w(pwdata[7:0], pwdata[15:8]);
    else if (done && pwrite && paddr == `LK_REG_STATUS && pwdata[0])
      abort_q <= 1'b0;
  end

  sequence s_data_read;
    psel && penable && pready_q && !pwrite && paddr == `LK_REG_DATA && !pslverr_q;
  endsequence

  sequence s_sel_write(logic [7:0] log);
    psel && penable && pready_q && pwrite && paddr == `LK_REG_LOG_SEL && pwdata[7:0] == log;
  endsequence

  a_dir_version: assert property (@(posedge clk) disable iff (rst)
    s_data_read and (sel_log_q == `LK_LOG_DIR && ofs_q == 9'h000 && dir_en_q)
    |-> prdata_q[7:0] == 8'h01)
    else $error("directory version low byte is not 01h");

  a_dir_absent: assert property (@(posedge clk) disable iff (rst)
    s_data_read and (sel_log_q == `LK_LOG_DIR && ofs_q != `LK_OFS_CKSUM && !dir_en_q)
    |-> prdata_q == 32'h0)
    else $error("disabled directory returned nonzero data");

  a_host_len: assert property (@(posedge clk) disable iff (rst)
    s_data_read and (sel_log_q == `LK_LOG_DIR && dir_en_q && ofs_q[8] && !ofs_q[7]
    && ofs_q[6] == 1'b0 && !ofs_q[0]) |-> prdata_q[7:0] == 8'h10)
    else $error("host log length is not sixteen sectors");

  a_fault_skip: assert property (@(posedge clk) disable iff (rst)
    err_valid && err_ev.host_fault |=> $stable(err_cnt_q) && $stable(err_idx_q))
    else $error("host fault changed the error log");

  a_err_version: assert property (@(posedge clk) disable iff (rst)
    s_data_read and (sel_log_q == `LK_LOG_ERR && ofs_q == 9'h000)
    |-> prdata_q[7:0] == `LK_LOG_VERSION)
    else $error("error log version is not 01h");

  a_err_wrap: assert property (@(posedge clk) disable iff (rst)
    err_take && err_idx_q == 3'h4 |=> err_idx_q == 3'h1 ##0 err_idx_q <= 3'h4)
    else $error("error index did not wrap to the first slot");

  a_cnt_sat: assert property (@(posedge clk) disable iff (rst)
    err_take |=> err_cnt_q ==
      (($past(err_cnt_q) == 16'hffff) ? 16'hffff : $past(err_cnt_q) + 16'h1))
    else $error("lifetime error count wrapped or missed an error");

  a_st_wrap: assert property (@(posedge clk) disable iff (rst)
    st_valid && st_idx_q == 5'h12 |=> st_idx_q == 5'h01)
    else $error("self-test index did not wrap to descriptor 1");

  a_legacy_abort: assert property (@(posedge clk) disable iff (rst)
    s_sel_write(`LK_LOG_ST_OLD) |=> abort_q ##1 (abort_q || $past(pwrite)))
    else $error("legacy self-test log access was not aborted");
endmodule : log_keeper

// file: rtl/log_keeper_params.svh
`ifndef LOG_KEEPER_PARAMS_SVH
`define LOG_KEEPER_PARAMS_SVH
`define LK_REG_CTRL 12'h000
`define LK_REG_LOG_SEL 12'h004
`define LK_REG_BYTE_OFS 12'h008
`define LK_REG_DATA 12'h00c
`define LK_REG_STATUS 12'h010
`define LK_CTRL_RESET 1'b1
`define LK_LOG_DIR 8'h00
`define LK_LOG_ERR 8'h03
`define LK_LOG_ST_OLD 8'h06
`define LK_LOG_ST 8'h07
`define LK_HOST_LO 8'h80
`define LK_HOST_HI 8'h9f
`define LK_HOST_SECTORS 16'h0010
`define LK_ONE_SECTOR 16'h0001
`define LK_GPL_VERSION 16'h0001
`define LK_LOG_VERSION 8'h01
`define LK_OFS_VER_HI 9'h001
`define LK_OFS_IDX_LO 9'h002
`define LK_OFS_IDX_HI 9'h003
`define LK_OFS_ENTRIES 9'h004
`define LK_OFS_ERR_END 9'h1f3
`define LK_OFS_ST_END 9'h1d7
`define LK_OFS_CNT_LO 9'h1f4
`define LK_OFS_CNT_HI 9'h1f5
`define LK_OFS_CKSUM 9'h1ff
`define LK_ERR_MAX_IDX 3'h4
`define LK_ST_MAX_IDX 5'h12
`define LK_CNT_MAX 16'hffff
`define LK_ERR_ENTRY 124
`define LK_CMD_REC 18
`define LK_CMD_HIST 5
`define LK_ERR_REC_OFS 90
`define LK_REC_STATUS 11
`define LK_REC_STATE 31
`define LK_REC_LIFE 32
`define LK_TS_OFS 14
`define LK_ST_ENTRY 26
`define LK_ST_LBA_OFS 5
`define LK_ERR_MEM 496
`define LK_ST_MEM 468
`define LK_SUM_LAST 511
`define LK_MS_NS 1000000
`define LK_CLK_NS 4
`endif

// file: tb/lk_host.sv
`timescale 1ns/100ps
module lk_host (
  input wire logic clk, // bus clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [11:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // request held until pready is seen at a rising edge, the only edge that counts
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // released lines carry junk so a stale value is never mistaken for a live one
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : lk_host

// file: tb/tb.sv
`timescale 1ns/100ps
`include "log_keeper_params.svh"
module tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, log_abort, e;
  logic cmd_valid, err_valid, st_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] life_hours, r, hrs;
  logic [127:0] w;
  logic [7:0] sec [512];
  lk_pkg::task_file_t cmd_tf;
  lk_pkg::task_file_t hist [5];
  lk_pkg::err_event_t err_ev, ev;
  lk_pkg::selftest_t st_res, sv;
  int error_cnt, checked, cyc, i, j, k, b;

  log_keeper #(.CYC_PER_MS(4)) log_keeper_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_tf(cmd_tf),
    .err_valid(err_valid), .err_ev(err_ev), .st_valid(st_valid), .st_res(st_res),
    .life_hours(life_hours), .log_abort(log_abort));
  lk_host lk_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // byte offset of the slot that the n-th logged event lands in
  function automatic int eslot(input int n);
    return 4 + 124 * ((n - 1) % 4);
  endfunction : eslot
  function automatic int dslot(input int n);
    return 4 + 26 * ((n - 1) % 18);
  endfunction : dslot

  task automatic chk(input string n, input logic [47:0] x, input logic [47:0] g);
    checked++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    lk_host_i.xfer(1'h1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    lk_host_i.xfer(1'h0, a, 32'h0, q, e);
  endtask : rd
  task automatic rsec(input logic [7:0] lg);
    logic [7:0] s;
    s = 8'h00;
    wr(`LK_REG_LOG_SEL, {24'h0, lg});
    for (int n = 0; n < 512; n++)
    begin
      rd(`LK_REG_DATA);
      sec[n] = q[7:0];
      s += q[7:0];
    end
    chk("checksum", 8'h00, s);
  endtask : rsec
  task automatic rndw();
    for (int n = 0; n < 8; n++)
    begin
      r = lfsr(r);
      w[16*n +: 16] = r;
    end
  endtask : rndw
  task automatic cmd_go();
    rndw();
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_tf <= w[103:0];
    @(posedge clk);
    cmd_valid <= 1'h0;
    for (int n = 0; n < 4; n++)
      hist[n] = hist[n + 1];
    hist[4] = w[103:0];
  endtask : cmd_go
  task automatic err_go(input logic hf);
    lk_pkg::err_event_t v;
    rndw();
    v = w[92:0];
    v.host_fault = hf;
    @(posedge clk);
    err_valid <= 1'h1;
    err_ev <= v;
    life_hours <= w[120:105];
    @(posedge clk);
    err_valid <= 1'h0;
    if (!hf)
    begin
      ev = v;
      hrs = w[120:105];
    end
  endtask : err_go

  initial
  begin
    rst <= 1'h1;
    cmd_valid <= 1'h0;
    err_valid <= 1'h0;
    st_valid <= 1'h0;
    cmd_tf <= '0;
    err_ev <= '0;
    st_res <= '0;
    life_hours <= 16'h0000;
    r = 16'h003c;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rsec(`LK_LOG_DIR);
    chk("dir version", 16'h0001, {sec[1], sec[0]});
    for (i = 128; i < 160; i++)
      chk("host log size", 16'h0010, {sec[2*i+1], sec[2*i]});
    wr(`LK_REG_CTRL, 32'h0);
    rsec(`LK_LOG_DIR);
    chk("dir absent", 16'h0000, {sec[1], sec[0]});
    wr(`LK_REG_CTRL, 32'h1);
    $display("directory test done");
    for (k = 1; k <= 5; k++)
    begin
      repeat (5) cmd_go();
      err_go(1'h0);
      // a faulty host command right after must leave entry, index and count alone
      if (k == 2)
        err_go(1'h1);
      rsec(`LK_LOG_ERR);
      b = eslot(k);
      chk("err version", 8'h01, sec[0]);
      chk("err index", (k - 1) % 4 + 1, {sec[3], sec[2]});
      chk("err count", k, {sec[501], sec[500]});
      for (i = 0; i < 5; i++)
        for (j = 0; j < 13; j++)
          chk("cmd record", hist[i][103-8*j -: 8], sec[b+18*i+j]);
      chk("stamp order", 1, {sec[b+89], sec[b+88], sec[b+87], sec[b+86]} >
          {sec[b+17], sec[b+16], sec[b+15], sec[b+14]});
      for (j = 0; j < 11; j++)
        chk("err record", ev[92-8*j -: 8], sec[b+91+j]);
      chk("state", {4'h0, ev.state}, sec[b+121]);
      chk("life stamp", hrs, {sec[b+123], sec[b+122]});
      for (i = b + 124; i < 500 && k < 4; i++)
        chk("unused slot", 8'h00, sec[i]);
    end
    $display("error log test done");
    for (k = 1; k <= 19; k++)
    begin
      rndw();
      sv = w[72:0];
      sv.legacy28 = (k == 1);
      @(posedge clk);
      st_valid <= 1'h1;
      st_res <= sv;
      life_hours <= w[95:80];
      @(posedge clk);
      st_valid <= 1'h0;
      if (k == 1 || k == 19)
      begin
        rsec(`LK_LOG_ST);
        b = dslot(k);
        chk("st revision", 8'h01, sec[0]);
        chk("st index", 16'h0001, {sec[3], sec[2]});
        chk("st head", {sv.number, sv.exec_status, w[95:80], sv.checkpoint},
            {sec[b], sec[b+1], sec[b+3], sec[b+2], sec[b+4]});
        chk("st lba", sv.legacy28 ? {20'h0, sv.lba[27:0]} : sv.lba, {sec[b+10], sec[b+9],
            sec[b+8], sec[b+7], sec[b+6], sec[b+5]});
        for (i = 30; i < 498 && k == 1; i++)
          chk("unused desc", 8'h00, sec[i]);
      end
    end
    $display("self-test log test done");
    wr(`LK_REG_LOG_SEL, {24'h0, `LK_LOG_ST_OLD});
    @(negedge clk);
    chk("abort flag", 1'h1, log_abort);
    rd(`LK_REG_DATA);
    chk("abort read", 1'h1, e);
    rd(`LK_REG_STATUS);
    chk("abort status", 1'h1, q[0]);
    wr(`LK_REG_DATA, 32'h0);
    chk("data write", 1'h1, e);
    wr(12'h0f0, 32'h0);
    chk("unmapped", 1'h1, e);
    wr(`LK_REG_STATUS, 32'h1);
    @(negedge clk);
    chk("abort w1c", 1'h0, log_abort);
    wr(`LK_REG_LOG_SEL, {24'h0, `LK_LOG_ST_OLD});
    @(negedge clk);
    chk("abort again", 1'h1, log_abort);
    wr(`LK_REG_LOG_SEL, {24'h0, `LK_LOG_ERR});
    @(negedge clk);
    chk("abort clear", 1'h0, log_abort);
    $display("abort test done");
    // one long burst of device errors drives the count past its ceiling
    @(posedge clk);
    err_valid <= 1'h1;
    repeat (65535) @(posedge clk);
    err_valid <= 1'h0;
    rd(`LK_REG_STATUS);
    chk("count ceiling", 16'hffff, q[31:16]);
    chk("err index wrap", 3'h4, q[3:1]);
    $display("saturation test done");
    // a second reset in mid-run must clear indexes, count and abort, and reselect the directory
    wr(`LK_REG_LOG_SEL, {24'h0, `LK_LOG_ST_OLD});
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(`LK_REG_STATUS);
    chk("reset status", 32'h0, q);
    chk("reset abort", 1'h0, log_abort);
    rd(`LK_REG_DATA);
    chk("reset selection", 8'h01, q[7:0]);
    $display("reset test done");
    close_out();
  end
endmodule : tb
